// *** lis_map.svh ***
`ifndef LIS_MAP_SVH
`define LIS_MAP_SVH

// register byte offsets
`define LIS_CTRL_OFS 12'h000
`define LIS_STAT_OFS 12'h004
`define LIS_FAULT_OFS 12'h008
`define LIS_ADDR_OFS 12'h00c

// control fields
`define LIS_CTRL_GATE_EN 0
`define LIS_CTRL_AUTORETRY 1
`define LIS_CTRL_GPIO_MODE_LO 2
`define LIS_CTRL_GPIO_LEVEL 4
`define LIS_CTRL_MUX_LO 5

// status fields
`define LIS_STAT_OV 0
`define LIS_STAT_UV 1
`define LIS_STAT_PGOOD 2
`define LIS_STAT_ARMED 3
`define LIS_STAT_GATE 4
`define LIS_STAT_GPIO_IN 5
`define LIS_STAT_ILIM 6
`define LIS_STAT_STATE_LO 8

// fault fields
`define LIS_FAULT_OV 0
`define LIS_FAULT_UV 1
`define LIS_FAULT_OC 2

// defaults loaded by the power-on-reset pulse
`define LIS_AUTORETRY_RST 1'b0
`define LIS_GPIO_MODE_RST 2'h0
`define LIS_GPIO_LEVEL_RST 1'b1
`define LIS_MUX_RST 2'h0

// gpio modes
`define LIS_GPIO_PGOOD 2'h0
`define LIS_GPIO_PBAD 2'h1
`define LIS_GPIO_INPUT 2'h2
`define LIS_GPIO_OUTPUT 2'h3

// timing
`define LIS_CLK_MHZ 250
`define LIS_TICK_NS 1000
`define LIS_TICK_CYCLES (`LIS_TICK_NS * `LIS_CLK_MHZ / 1000)
`define LIS_POR_US 60
`define LIS_QUAL_MS 100
`define LIS_START_MS 100
`define LIS_COOL_S 5
`define LIS_CB_FILTER_US 20

`endif

// *** lis_pkg.sv ***
package lis_pkg;

  typedef enum logic [2:0] {
    ST_DOWN,
    ST_POR,
    ST_QUAL,
    ST_OFF,
    ST_START,
    ST_RUN,
    ST_COOL
  } lis_state_e;

  typedef struct packed {
    logic [19:0] s1;
    logic [19:0] s2;
    lis_state_e st;
    logic [22:0] cnt;
    logic [9:0] cb_cnt;
    logic [7:0] div;
    logic tick;
    logic on_prev;
    logic gate_en;
    logic autoretry;
    logic [1:0] gpio_mode;
    logic gpio_level;
    logic [1:0] mux;
    logic [2:0] fault;
    logic armed;
    logic gate_on;
    logic ilim_run;
    logic timer_charge;
    logic pgood;
    logic gpio_oe;
    logic gpio_o;
    logic [4:0] addr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lis_regs_s;

endpackage

// *** lis_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lis_map.svh"

module lis_sequencer #(
  parameter int unsigned POR_CYCLES = `LIS_POR_US * `LIS_CLK_MHZ,
  parameter int unsigned QUAL_TICKS = `LIS_QUAL_MS * 1000,
  parameter int unsigned START_TICKS = `LIS_START_MS * 1000,
  parameter int unsigned COOL_TICKS = `LIS_COOL_S * 1000000,
  parameter int unsigned CB_FILTER_TICKS = `LIS_CB_FILTER_US,
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_undervolt_cmp,
  input wire logic input_overvolt_cmp,
  input wire logic supply_overvolt_cmp,
  input wire logic input_supply_lockout,
  input wire logic internal_supply_lockout,
  input wire logic enable_n,
  input wire logic on_in,
  input wire logic power_good_cmp,
  input wire logic breaker_detector,
  input wire logic current_limit_cmp,
  input wire logic timer_threshold_cmp,
  input wire logic cooldown_cmp,
  input wire logic timer_strap,
  input wire logic gpio_i,
  input wire logic [1:0] address_select_0,
  input wire logic [1:0] address_select_1,
  input wire logic [1:0] address_select_2,
  output logic gate_on,
  output logic ilim_run,
  output logic timer_charge,
  output logic breaker_armed,
  output logic gpio_o,
  output logic gpio_oe,
  output logic [1:0] adc_mux_sel,
  output logic [4:0] slave_addr
);

  lis_pkg::lis_regs_s q;
  lis_pkg::lis_regs_s n;

  // tri-state pin code: 00 ground, 01 or 11 open, 10 tied high
  function automatic logic [4:0] trit(input logic [1:0] code);
    case (code)
      2'h0: trit = 5'h00;
      2'h2: trit = 5'h02;
      default: trit = 5'h01;
    endcase
  endfunction

  function automatic logic reached(input logic [22:0] cnt, input int unsigned lim);
    reached = cnt >= 23'(lim);
  endfunction

  logic s_uv;
  logic s_ov;
  logic s_sov;
  logic s_vlock;
  logic s_ilock;
  logic s_en_n;
  logic s_on;
  logic s_pg;
  logic s_cb;
  logic s_ilim;
  logic s_tmr;
  logic s_cool;
  logic s_strap;
  logic s_gpio;
  logic [1:0] s_a0;
  logic [1:0] s_a1;
  logic [1:0] s_a2;
  logic qual;
  logic on_rise;
  logic on_fall;
  logic wr;
  logic [31:0] rdata;
  logic mapped;
  logic [4:0] a1;
  logic [4:0] a2;

  assign s_uv = q.s2[0];
  assign s_ov = q.s2[1];
  assign s_sov = q.s2[2];
  assign s_vlock = q.s2[3];
  assign s_ilock = q.s2[4];
  assign s_en_n = q.s2[5];
  assign s_on = q.s2[6];
  assign s_pg = q.s2[7];
  assign s_cb = q.s2[8];
  assign s_ilim = q.s2[9];
  assign s_tmr = q.s2[10];
  assign s_cool = q.s2[11];
  assign s_strap = q.s2[12];
  assign s_gpio = q.s2[13];
  assign s_a0 = q.s2[15:14];
  assign s_a1 = q.s2[17:16];
  assign s_a2 = q.s2[19:18];

  assign qual = !s_vlock && !s_uv && !s_ov && !s_sov && !s_en_n;
  assign on_rise = s_on && !q.on_prev;
  assign on_fall = !s_on && q.on_prev;
  assign wr = psel && penable && pwrite && q.pready;

  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0;
    case (paddr)
      `LIS_CTRL_OFS: begin
        rdata[`LIS_CTRL_GATE_EN] = q.gate_en;
        rdata[`LIS_CTRL_AUTORETRY] = q.autoretry;
        rdata[`LIS_CTRL_GPIO_MODE_LO +: 2] = q.gpio_mode;
        rdata[`LIS_CTRL_GPIO_LEVEL] = q.gpio_level;
        rdata[`LIS_CTRL_MUX_LO +: 2] = q.mux;
      end
      `LIS_STAT_OFS: begin
        rdata[`LIS_STAT_OV] = s_ov | s_sov;
        rdata[`LIS_STAT_UV] = s_uv;
        rdata[`LIS_STAT_PGOOD] = q.pgood;
        rdata[`LIS_STAT_ARMED] = q.armed;
        rdata[`LIS_STAT_GATE] = q.gate_on;
        rdata[`LIS_STAT_GPIO_IN] = s_gpio;
        rdata[`LIS_STAT_ILIM] = s_ilim;
        rdata[`LIS_STAT_STATE_LO +: 3] = q.st;
      end
      `LIS_FAULT_OFS: rdata[2:0] = q.fault;
      `LIS_ADDR_OFS: rdata[4:0] = q.addr;
      default: mapped = 1'b0;
    endcase
  end

  // missing pins on the small package read as open
  assign a1 = SMALL_PKG ? 5'h01 : trit(s_a1);
  assign a2 = SMALL_PKG ? 5'h01 : trit(s_a2);

  always_comb begin
    n = q;
    n.s1 = {address_select_2, address_select_1, address_select_0, gpio_i, timer_strap,
            cooldown_cmp, timer_threshold_cmp, current_limit_cmp, breaker_detector,
            power_good_cmp, on_in, enable_n, internal_supply_lockout,
            input_supply_lockout, supply_overvolt_cmp, input_overvolt_cmp,
            input_undervolt_cmp};
    n.s2 = q.s1;
    n.on_prev = s_on;

    n.tick = q.div == 8'(`LIS_TICK_CYCLES - 1);
    n.div = n.tick ? 8'h00 : q.div + 8'h01;
    n.cnt = q.tick ? q.cnt + 23'h1 : q.cnt;

    n.addr = 5'(a2 * 5'd9 + a1 * 5'd3 + trit(s_a0));

    // apb: answer in the second access cycle, effect at its closing edge
    n.pready = psel && penable && !q.pready;
    n.pslverr = n.pready && !mapped;
    n.prdata = n.pready && !pwrite && mapped ? rdata : 32'h0;
    if (wr && mapped && paddr == `LIS_CTRL_OFS) begin
      n.gate_en = pwdata[`LIS_CTRL_GATE_EN];
      n.autoretry = pwdata[`LIS_CTRL_AUTORETRY];
      n.gpio_mode = pwdata[`LIS_CTRL_GPIO_MODE_LO +: 2];
      n.gpio_level = pwdata[`LIS_CTRL_GPIO_LEVEL];
      n.mux = pwdata[`LIS_CTRL_MUX_LO +: 2];
    end
    // writing zero clears a flag; hardware sets below still win
    if (wr && mapped && paddr == `LIS_FAULT_OFS) begin
      n.fault = q.fault & pwdata[2:0];
    end

    // pin edges after the bus write so the pin wins a tie
    if (q.st >= lis_pkg::ST_OFF) begin
      if (on_rise) begin
        n.gate_en = 1'b1;
      end
      if (on_fall) begin
        n.gate_en = 1'b0;
      end
    end

    if (q.st >= lis_pkg::ST_START && q.st <= lis_pkg::ST_RUN) begin
      if (s_uv) begin
        n.fault[`LIS_FAULT_UV] = 1'b1;
      end
      if (s_ov) begin
        n.fault[`LIS_FAULT_OV] = 1'b1;
      end
    end
    if (s_sov && q.st != lis_pkg::ST_DOWN && q.st != lis_pkg::ST_POR) begin
      n.fault[`LIS_FAULT_OV] = 1'b1;
    end

    case (q.st)
      lis_pkg::ST_DOWN: begin
        n.cnt = 23'h0;
        if (!s_ilock) begin
          n.st = lis_pkg::ST_POR;
        end
      end
      lis_pkg::ST_POR: begin
        n.cnt = q.cnt + 23'h1;
        n.fault = 3'h0;
        n.gate_en = 1'b0;
        n.autoretry = `LIS_AUTORETRY_RST;
        n.gpio_mode = `LIS_GPIO_MODE_RST;
        n.gpio_level = `LIS_GPIO_LEVEL_RST;
        n.mux = `LIS_MUX_RST;
        if (reached(q.cnt, POR_CYCLES - 1)) begin
          n.st = lis_pkg::ST_QUAL;
        end
      end
      lis_pkg::ST_QUAL: begin
        // any bounce restarts the full interval
        if (!qual) begin
          n.cnt = 23'h0;
        // one extra tick: the first tick may fall right after entry
        end else if (reached(q.cnt, QUAL_TICKS + 1)) begin
          n.gate_en = s_on;
          n.st = lis_pkg::ST_OFF;
        end
      end
      lis_pkg::ST_OFF: begin
        if (!qual) begin
          n.st = lis_pkg::ST_QUAL;
        end else if (n.gate_en && (q.autoretry || !q.fault[`LIS_FAULT_OC])) begin
          n.st = lis_pkg::ST_START;
        end
      end
      lis_pkg::ST_START: begin
        if (!qual) begin
          n.st = lis_pkg::ST_QUAL;
        end else if (!n.gate_en) begin
          n.st = lis_pkg::ST_OFF;
        end else if (s_strap ? reached(q.cnt, START_TICKS + 1) : s_tmr) begin
          if (s_ilim) begin
            n.fault[`LIS_FAULT_OC] = 1'b1;
            n.st = lis_pkg::ST_COOL;
          end else begin
            n.st = lis_pkg::ST_RUN;
          end
        end
      end
      lis_pkg::ST_RUN: begin
        n.cb_cnt = !s_cb ? 10'h0 : (q.tick ? q.cb_cnt + 10'h1 : q.cb_cnt);
        if (!qual) begin
          n.st = lis_pkg::ST_QUAL;
        end else if (!n.gate_en) begin
          n.st = lis_pkg::ST_OFF;
        end else if (q.cb_cnt > 10'(CB_FILTER_TICKS)) begin
          n.fault[`LIS_FAULT_OC] = 1'b1;
          n.st = lis_pkg::ST_COOL;
        end
      end
      lis_pkg::ST_COOL: begin
        // restart decision is made in ST_OFF
        if (s_strap ? reached(q.cnt, COOL_TICKS) : s_cool) begin
          n.st = lis_pkg::ST_OFF;
        end
      end
      default: n.st = lis_pkg::ST_DOWN;
    endcase

    if (s_ilock) begin
      n.st = lis_pkg::ST_DOWN;
    end
    if (n.st != q.st) begin
      n.cnt = 23'h0;
    end
    if (n.st != lis_pkg::ST_RUN) begin
      n.cb_cnt = 10'h0;
    end

    n.gate_on = n.st == lis_pkg::ST_START || n.st == lis_pkg::ST_RUN;
    n.timer_charge = n.st == lis_pkg::ST_START;
    n.armed = n.st == lis_pkg::ST_RUN;
    n.ilim_run = n.armed;
    n.pgood = n.armed && s_pg;

    n.gpio_o = 1'b0;
    case (n.gpio_mode)
      `LIS_GPIO_PGOOD: n.gpio_oe = !n.pgood;
      `LIS_GPIO_PBAD: n.gpio_oe = n.pgood;
      `LIS_GPIO_INPUT: n.gpio_oe = 1'b0;
      default: n.gpio_oe = !n.gpio_level;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign gate_on = q.gate_on;
  assign ilim_run = q.ilim_run;
  assign timer_charge = q.timer_charge;
  assign breaker_armed = q.armed;
  assign gpio_o = q.gpio_o;
  assign gpio_oe = q.gpio_oe;
  assign adc_mux_sel = q.mux;
  assign slave_addr = q.addr;

endmodule

`default_nettype wire

// *** lis_analog.sv ***
`timescale 1ns/1ps
`default_nettype none
// timer cap, feedback and sense comparators seen from the logic
module lis_analog #(
  parameter int TC = 100
) (
  input wire logic pclk,
  input wire logic gate_on,
  input wire logic timer_charge,
  input wire logic short_load,
  output logic timer_threshold_cmp,
  output logic cooldown_cmp,
  output logic power_good_cmp,
  output logic current_limit_cmp
);
  int tc = 0;
  // cap charges only in start-up and bleeds down otherwise
  always @(posedge pclk)
    tc <= timer_charge ? (tc < TC ? tc + 1 : TC) : (tc > 0 ? tc - 1 : 0);
  assign timer_threshold_cmp = tc >= TC;
  assign cooldown_cmp = tc == 0;
  assign power_good_cmp = gate_on && !short_load;
  assign current_limit_cmp = gate_on && short_load;
endmodule
`default_nettype wire

// *** lis_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lis_sequencer_assertions #(
  parameter int unsigned CB_FILTER_TICKS = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic input_supply_lockout,
  input wire logic supply_overvolt_cmp,
  input wire logic breaker_detector,
  input wire logic gate_on,
  input wire logic ilim_run,
  input wire logic timer_charge,
  input wire logic breaker_armed,
  input wire logic [1:0] adc_mux_sel,
  input wire logic [4:0] slave_addr
);
  // slack of two ticks covers tick phase and synchroniser delay
  localparam int CBMAX = (CB_FILTER_TICKS + 2) * 250;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] cb_q;
  logic [15:0] cb_d;
  logic wr_q;
  assign cb_d = (breaker_armed && breaker_detector) ? cb_q + 16'h1 : 16'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_q <= 16'h0;
      wr_q <= 1'b0;
    end else begin
      cb_q <= cb_d;
      wr_q <= psel && penable && pwrite;
    end
  end
  property p_lock;
    input_supply_lockout [*6] |-> !gate_on;
  endproperty
  a_lock: assert property (p_lock) else $error("gate on under lockout");
  property p_ov;
    supply_overvolt_cmp [*6] |-> !gate_on;
  endproperty
  a_ov: assert property (p_ov) else $error("gate on under supply overvoltage");
  property p_arm;
    breaker_armed |-> gate_on && ilim_run && !timer_charge;
  endproperty
  a_arm: assert property (p_arm) else $error("armed without running limit");
  property p_chg;
    timer_charge |-> gate_on && !breaker_armed;
  endproperty
  a_chg: assert property (p_chg) else $error("timer runs outside start-up");
  property p_cb;
    cb_q <= CBMAX;
  endproperty
  a_cb: assert property (p_cb) else $error("breaker trip too late");
  property p_rdy;
    psel && !penable |-> ##2 pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err;
    pready |-> pslverr == (paddr[11:4] != 8'h0 || paddr[1:0] != 2'h0);
  endproperty
  a_err: assert property (p_err) else $error("wrong slave error");
  property p_mux;
    $changed(adc_mux_sel) |-> wr_q || $past(wr_q);
  endproperty
  a_mux: assert property (p_mux) else $error("mux moved without write");
  property p_addr;
    slave_addr <= 5'h1a;
  endproperty
  a_addr: assert property (p_addr) else $error("address out of range");
endmodule
bind lis_sequencer lis_sequencer_assertions #(.CB_FILTER_TICKS(CB_FILTER_TICKS)) lis_sequencer_assertions_i (.*);
`default_nettype wire

// *** lis_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module lis_sequencer_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, gate_on, ilim_run, timer_charge, breaker_armed, gpio_o, gpio_oe, gpio_i;
  logic input_undervolt_cmp = 0, input_overvolt_cmp = 0, supply_overvolt_cmp = 0;
  logic input_supply_lockout = 1, internal_supply_lockout = 1, enable_n = 0, on_in = 1;
  logic breaker_detector = 0, timer_strap = 0, short_load = 0;
  logic power_good_cmp, current_limit_cmp, timer_threshold_cmp, cooldown_cmp;
  logic [1:0] address_select_0 = 2'h2, address_select_1 = 2'h1, address_select_2 = 2'h0, adc_mux_sel;
  logic [4:0] slave_addr;
  int fails = 0, n_tests = 0, n;
  // open-drain pin with pull-up
  assign gpio_i = !gpio_oe;
  always #2 pclk = ~pclk;
  lis_sequencer #(.POR_CYCLES(20), .QUAL_TICKS(5), .START_TICKS(5), .COOL_TICKS(10), .CB_FILTER_TICKS(3))
    lis_sequencer_i (.*);
  lis_analog lis_analog_i (.*);
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wg(input logic v);
    n = 0;
    while (gate_on !== v && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk("gate", gate_on, v);
  endtask
  task automatic results;
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #80000;
    fails++;
    results();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    // address pins need the synchroniser and one register stage
    repeat (4) @(posedge pclk);
    bus(0, 12'h00c, 0);
    chk("addr", r, 32'h5);
    bus(0, 12'h010, 0);
    chk("err", {r[30:0], e}, 32'h1);
    internal_supply_lockout <= 0;
    repeat (100) @(posedge pclk);
    bus(0, 12'h000, 0);
    chk("ctrl", r, 32'h10);
    for (int m = 0; m < 3; m++) begin
      bus(1, 12'h000, 32'h10 | (m << 5));
      repeat (3) @(posedge pclk);
      chk("mux", adc_mux_sel, m);
    end
    repeat (2000) @(posedge pclk);
    chk("lock", gate_on, 0);
    enable_n <= 1;
    input_supply_lockout <= 0;
    repeat (50) @(posedge pclk);
    enable_n <= 0;
    wg(1);
    chk("qual", n >= 1250, 1);
    bus(0, 12'h000, 0);
    chk("ctrl", r, 32'h51);
    repeat (400) @(posedge pclk);
    bus(0, 12'h004, 0);
    chk("stat", r, 32'h53c);
    bus(0, 12'h008, 0);
    chk("fault", r, 0);
    breaker_detector <= 1;
    wg(0);
    chk("filt", n >= 750, 1);
    breaker_detector <= 0;
    bus(0, 12'h008, 0);
    chk("oc", r, 4);
    repeat (600) @(posedge pclk);
    chk("latch", gate_on, 0);
    bus(1, 12'h008, 0);
    wg(1);
    bus(1, 12'h000, 32'h13);
    repeat (400) @(posedge pclk);
    breaker_detector <= 1;
    wg(0);
    breaker_detector <= 0;
    wg(1);
    bus(0, 12'h008, 0);
    chk("keep", r, 4);
    repeat (400) @(posedge pclk);
    on_in <= 0;
    wg(0);
    bus(1, 12'h000, 32'h13);
    wg(1);
    bus(1, 12'h000, 32'h12);
    wg(0);
    bus(1, 12'h008, 0);
    short_load <= 1;
    on_in <= 1;
    wg(1);
    wg(0);
    short_load <= 0;
    bus(0, 12'h008, 0);
    chk("short", r, 4);
    wg(1);
    repeat (400) @(posedge pclk);
    supply_overvolt_cmp <= 1;
    wg(0);
    chk("ovt", n < 8, 1);
    supply_overvolt_cmp <= 0;
    input_undervolt_cmp <= 1;
    repeat (10) @(posedge pclk);
    bus(0, 12'h004, 0);
    chk("uv", r[1:0], 2'h2);
    bus(0, 12'h008, 0);
    chk("flt", r[2:0], 3'h5);
    results();
  end
endmodule
`default_nettype wire
